// file: include/gdp_pkg.sv
// package for the gate drive protection logic
package gdp_pkg;
   localparam int NUM_PHASES = 3;
   // timing in ns, as figures of the block
   localparam int CLK_PERIOD_NS = 20;
   localparam int DEAD_TIME_NS  = 200;
   localparam int MIN_ON_NS     = 200;
   // least times round up
   localparam int DEAD_CYCLES   = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_ON_CYCLES = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   // per-phase drive state, gray along off->low/high paths except the off->dead step (00->11)
   typedef enum logic [1:0] {
      GDP_OFF  = 2'b00,
      GDP_LOW  = 2'b01,
      GDP_DEAD = 2'b11,
      GDP_HIGH = 2'b10
   } gdp_drive_e;

   typedef struct packed {
      logic       high_side_command;
      logic       low_side_command_n;
   } gdp_cmd_s;

   typedef struct packed {
      logic [NUM_PHASES-1:0] bootstrap_undervolt_lock;
      logic                  supply_undervolt_lock;
      logic                  regulator_undervolt_lock;
      logic                  over_temperature;
   } gdp_fault_s;

   typedef struct packed {
      gdp_drive_e             drive;
      gdp_drive_e             target;
      logic [CNT_W-1:0]       dead_cnt;
      logic [CNT_W-1:0]       filt_cnt;
      logic [1:0]             cand;
      logic                   gh;
      logic                   gl;
   } gdp_phase_s;

   typedef struct packed {
      gdp_phase_s [NUM_PHASES-1:0] ph;
      logic                        boot_en;
   } gdp_state_s;
endpackage : gdp_pkg

// file: testbench/gdp_gate_drive_bench.sv
// self-checking bench for the gate drive block
`timescale 1ns/1ps
module gdp_gate_drive_bench
   import gdp_pkg::*;
;
   logic ref_clk = 0, arst_n = 0, enable = 0, probe = 0, be;
   logic [5:0] req = 6'h00;
   logic [2:0] hs, ls;
   logic [6:0] q[$], e;
   logic [31:0] r = 32'h0000_005a;
   gdp_fault_s fault = '0;
   gdp_cmd_s [2:0] cmd;
   int n_errors = 0, check_count = 0;
   initial forever #10 ref_clk = ~ref_clk;
   gdp_pwm_model i_pwm (.ref_clk(ref_clk), .enable(enable), .req(req), .phase_cmd(cmd));
   gdp_gate_drive i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .enable(enable), .phase_cmd(cmd),
      .fault(fault), .high_side_gate_out(hs), .low_side_gate_out(ls), .bootstrap_enable(be));
   task automatic step(input logic [5:0] c, input logic [5:0] f, input int n, input logic [6:0] x);
      req <= c;
      fault <= f;
      repeat (n) @(negedge ref_clk);
      q.push_back(x);
      probe = 1;
      @(negedge ref_clk);
      probe = 0;
   endtask : step
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xorshift
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   always @(posedge probe)
   begin
      e = q.pop_front();
      check_count++;
      if ({be, hs, ls} !== e)
         $display("ERROR %0t got %h exp %h", $time, {be, hs, ls}, e);
      n_errors += ({be, hs, ls} !== e);
   end
   // cap well above the ~790 cycles needed
   initial
   begin
      repeat (2000) @(posedge ref_clk);
      n_errors++;
      give_verdict;
   end
   initial
   begin
      repeat (4) @(negedge ref_clk);
      arst_n = 1;
      step(6'h3f, 6'h00, 40, 7'h40);
      enable <= 1;
      step(6'h00, 6'h00, 40, 7'h47);
      step(6'h3f, 6'h00, 5, 7'h47);
      step(6'h00, 6'h00, 40, 7'h47);
      step(6'h3f, 6'h00, 40, 7'h78);
      step(6'h2a, 6'h00, 40, 7'h40);
      step(6'h3f, 6'h10, 40, 7'h68);
      step(6'h3f, 6'h05, 40, 7'h00);
      step(6'h3f, 6'h01, 40, 7'h00);
      step(6'h3f, 6'h02, 40, 7'h00);
      step(6'h3f, 6'h00, 40, 7'h78);
      enable <= 0;
      step(6'h3f, 6'h00, 4, 7'h40);
      enable <= 1;
      step(6'h00, 6'h00, 40, 7'h47);
      repeat (8)
      begin
         r = xorshift(r);
         step({{2{r[2]}}, {2{r[1]}}, {2{r[0]}}}, 6'h00, 40, {1'b1, r[2:0], ~r[2:0]});
      end
      give_verdict;
   end
endmodule : gdp_gate_drive_bench

// file: testbench/gdp_gate_drive_props.sv
// assertions on the gate drive outputs
`timescale 1ns/1ps
module gdp_gate_drive_props
   import gdp_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       arst_n,
   input wire logic       enable,
   input wire gdp_fault_s fault,
   input wire logic [2:0] high_side_gate_out,
   input wire logic [2:0] low_side_gate_out,
   input wire logic       bootstrap_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   wire [5:0] f = fault;
   wire [2:0] h = high_side_gate_out;
   wire [2:0] l = low_side_gate_out;
   wire o = (h | l) == 3'h0;
   gate_excl_a: assert property (!(h & l)) else $error("overlap");
   dead_gap_a: assert property ($fell(l[0]) |-> !h[0] [*8]) else $error("gap");
   en_off_a: assert property (!enable |-> ##2 o) else $error("enable");
   supply_lock_a: assert property (f[2] |=> o) else $error("supply");
   reg_lock_a: assert property (f[1] |=> o) else $error("regulator");
   temp_lock_a: assert property (f[0] |=> o) else $error("temperature");
   boot_lock_a: assert property (f[4] |=> !h[1]) else $error("bootstrap");
   boot_off_a: assert property ((|f[2:0]) |=> !bootstrap_enable) else $error("off");
   boot_on_a: assert property (!f[2:0] [*2] |=> bootstrap_enable) else $error("on");
endmodule : gdp_gate_drive_props
bind gdp_gate_drive gdp_gate_drive_props i_props (.ref_clk(ref_clk), .arst_n(arst_n),
   .enable(enable), .fault(fault), .high_side_gate_out(high_side_gate_out),
   .low_side_gate_out(low_side_gate_out), .bootstrap_enable(bootstrap_enable));

// file: testbench/gdp_pwm_model.sv
// pwm timer model driving the phase commands
`timescale 1ns/1ps
module gdp_pwm_model
   import gdp_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           enable,
   input  wire logic [5:0]     req,
   output gdp_cmd_s [2:0]      phase_cmd
);
   // charge time well beyond the on-time filter and dead time
   localparam int CHARGE_CYCLES = 32;
   int chg_q = 0;
   // low side first, charging the bootstrap
   always @(negedge ref_clk)
   begin
      chg_q <= !enable ? 0 : (chg_q < CHARGE_CYCLES) ? chg_q + 1 : chg_q;
      phase_cmd <= (chg_q == CHARGE_CYCLES) ? req : 6'h00;
   end
endmodule : gdp_pwm_model

// file: verilog/gdp_gate_drive.sv
// three-phase gate drive decode, dead time, min on-time and fault gating
// How it works
// R01: enable low clears gates; 1/1 drives high, 0/0 drives low, else off.
// R02: fixed dead time of all-off inserted on every high/low side change.
// R03: command patterns shorter than minimum on-time never reach the gates.
// R04: controller holds commands low after enable to charge bootstrap.
// R05: active faults force affected gates low over the decoded commands.
// R06: supply lockout holds all gates low and disables bootstrap.
// R07: supply lockout hysteresis lives in the comparator input level.
// R08: bootstrap lockout forces only that phase high side low.
// R09: high side returns only when that phase lockout releases.
// R10: regulator lockout forces all gates low, bootstrap disabled.
// R11: over temperature forces all gates low, bootstrap disabled.
// R12: faults independent, take priority; gate released when none remain.
`timescale 1ns/1ps
module gdp_gate_drive
   import gdp_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   input  wire logic                  enable,
   input  wire gdp_cmd_s [NUM_PHASES-1:0] phase_cmd,
   input  wire gdp_fault_s            fault,
   output logic [NUM_PHASES-1:0]      high_side_gate_out,
   output logic [NUM_PHASES-1:0]      low_side_gate_out,
   output logic                       bootstrap_enable
);
   localparam logic [CNT_W-1:0] DEAD_LAST  = CNT_W'(DEAD_CYCLES - 1);
   localparam logic [CNT_W-1:0] MINON_LAST = CNT_W'(MIN_ON_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;

   // whole block state lives in one register copy
   gdp_state_s                 st_q;
   gdp_state_s                 st_d;
   logic                       global_trip;
   wire logic [NUM_PHASES-1:0] hs_block;
   wire logic [NUM_PHASES-1:0] ls_block;

   // R01 truth table decode
   function automatic gdp_drive_e decode_cmd
   (
      input logic       en,
      input logic [1:0] pat
   );
      gdp_drive_e res;
      res = GDP_OFF;
      if (en)
      begin
         unique case (pat)
            2'b11:   res = GDP_HIGH;
            2'b00:   res = GDP_LOW;
            // split commands mean neither side
            2'b01,
            2'b10:   res = GDP_OFF;
         endcase
      end
      return res;
   endfunction : decode_cmd

   // R01 enable low turns off at once, bypassing the filter
   function automatic gdp_drive_e want_step
   (
      input logic       en,
      input gdp_drive_e target
   );
      gdp_drive_e res;
      res = GDP_OFF;
      if (en)
      begin
         res = target;
      end
      return res;
   endfunction : want_step

   // command pair as one pattern, high side in the upper bit
   function automatic logic [1:0] raw_pattern
   (
      input gdp_cmd_s cmd
   );
      return {cmd.high_side_command, cmd.low_side_command_n};
   endfunction : raw_pattern

   // R03 pattern must stay stable for the minimum on-time
   function automatic gdp_phase_s filter_step
   (
      input gdp_phase_s cur,
      input logic       en,
      input logic [1:0] pat
   );
      gdp_phase_s nxt;
      nxt = cur;
      if (pat != cur.cand)
      begin
         // restart on any change, so a short pulse never counts out
         nxt.cand     = pat;
         nxt.filt_cnt = CNT_RESET;
      end
      else if (cur.filt_cnt != MINON_LAST)
      begin
         nxt.filt_cnt = cur.filt_cnt + CNT_ONE;
      end
      else
      begin
         // pattern held long enough, take it
         nxt.target = decode_cmd(en, cur.cand);
      end
      return nxt;
   endfunction : filter_step

   // R02 all-off gap on every side change
   function automatic gdp_phase_s drive_step
   (
      input gdp_phase_s cur,
      input gdp_drive_e want
   );
      gdp_phase_s nxt;
      nxt = cur;
      unique case (cur.drive)
         GDP_OFF:
         begin
            // off-to-on also waits, covering abutting command edges
            if (want != GDP_OFF)
            begin
               nxt.drive    = GDP_DEAD;
               nxt.dead_cnt = CNT_RESET;
            end
         end
         GDP_DEAD:
         begin
            if (want == GDP_OFF)
            begin
               nxt.drive = GDP_OFF;
            end
            else if (cur.dead_cnt == DEAD_LAST)
            begin
               nxt.drive = want;
            end
            else
            begin
               nxt.dead_cnt = cur.dead_cnt + CNT_ONE;
            end
         end
         GDP_LOW, GDP_HIGH:
         begin
            // any change passes through all-off first
            if (want != cur.drive)
            begin
               nxt.drive = GDP_OFF;
            end
         end
      endcase
      return nxt;
   endfunction : drive_step

   // R05 R12 fault gating over the decode; faults skip filter and dead time
   function automatic gdp_phase_s gate_step
   (
      input gdp_phase_s cur,
      input logic       hs_blk,
      input logic       ls_blk
   );
      gdp_phase_s nxt;
      nxt    = cur;
      nxt.gh = (cur.drive == GDP_HIGH) & ~hs_blk;
      nxt.gl = (cur.drive == GDP_LOW) & ~ls_blk;
      return nxt;
   endfunction : gate_step

   // R06 R10 R11 all-phase trips; each fault input stays independent
   // R07 lock levels arrive with their hysteresis already applied
   assign global_trip = fault.supply_undervolt_lock | fault.regulator_undervolt_lock |
                        fault.over_temperature;

   // R05 R12 per-phase block masks, released only when no fault is left
   for (genvar g = 0; g < NUM_PHASES; g++)
   begin : g_mask
      // R08 R09 bootstrap lock hits only the high side of its phase
      assign hs_block[g] = global_trip | fault.bootstrap_undervolt_lock[g];
      assign ls_block[g] = global_trip;
   end

   always_comb
   begin
      gdp_phase_s ph;
      gdp_drive_e want;
      logic [1:0] raw;
      st_d = st_q;
      ph   = '0;
      want = GDP_OFF;
      raw  = 2'b00;
      // R06 R10 R11 bootstrap held off in global lockout
      st_d.boot_en = ~global_trip;
      for (int i = 0; i < NUM_PHASES; i++)
      begin
         raw        = raw_pattern(phase_cmd[i]);
         want       = want_step(enable, st_q.ph[i].target);
         ph         = filter_step(st_q.ph[i], enable, raw);
         ph         = drive_step(ph, want);
         ph         = gate_step(ph, hs_block[i], ls_block[i]);
         st_d.ph[i] = ph;
      end
   end

   // async clear puts every gate off at once
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs come straight from the state flops
   always_comb
   begin
      for (int i = 0; i < NUM_PHASES; i++)
      begin
         high_side_gate_out[i] = st_q.ph[i].gh;
         low_side_gate_out[i]  = st_q.ph[i].gl;
      end
      bootstrap_enable = st_q.boot_en;
   end
endmodule : gdp_gate_drive
